// *** agu_checker_assertions.sv ***
// concurrent checks on the ports of the address unit
`timescale 1ns/1ns
module agu_checker
  import agu_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic accessValid,
  input wire logic accessWrite,
  input wire logic [15:0] effAddr,
  input wire logic tableAccess,
  input wire logic tableHigh,
  input wire logic stackOp,
  input wire logic stackPop,
  input wire push_kind_type pushKind,
  input wire logic readPageWrite,
  input wire logic writePageWrite,
  input wire logic stackLimitWrite,
  input wire logic [9:0] dataReadPage,
  input wire logic [8:0] dataWritePage,
  input wire logic [7:0] tablePage,
  input wire logic [15:0] stackLimit,
  input wire logic [15:0] stackPointer,
  input wire logic lowDataStrobe,
  input wire logic extDataStrobe,
  input wire logic progStrobe,
  input wire logic memWrite,
  input wire logic [23:0] memAddr,
  input wire logic [15:0] memWriteData,
  input wire logic upperWordSel,
  input wire logic configSpace,
  input wire logic addressErrorTrap,
  input wire logic stackErrorTrap
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire plainAcc = accessValid && !tableAccess && !stackOp;
  wire pushAcc = accessValid && stackOp && !stackPop && !tableAccess;
  wire popAcc = accessValid && stackOp && stackPop && !tableAccess;
  a_ext_write_addr: assert property (
    plainAcc && accessWrite && effAddr[15] && dataWritePage != 9'h000 |=> extDataStrobe
    && memWrite && memAddr == {$past(dataWritePage), $past(effAddr[14:0])}) else $error("ext write");
  a_page_zero_trap: assert property (
    plainAcc && effAddr[15] && (accessWrite ? dataWritePage == 9'h000 : dataReadPage == 10'h000)
    |=> addressErrorTrap && !extDataStrobe && !progStrobe) else $error("page zero");
  a_prog_window_addr: assert property (
    plainAcc && !accessWrite && effAddr[15] && dataReadPage[9] |=> progStrobe && !configSpace
    && upperWordSel == $past(dataReadPage[8])
    && memAddr == {1'b0, $past(dataReadPage[7:0]), $past(effAddr[14:0])}) else $error("window");
  a_table_addr: assert property (
    accessValid && tableAccess && !(accessWrite && tablePage[7]) |=> progStrobe
    && configSpace == $past(tablePage[7]) && upperWordSel == $past(tableHigh)
    && memAddr == {$past(tablePage), $past(effAddr)}) else $error("table address");
  a_push_step: assert property (
    pushAcc && stackPointer <= stackLimit && stackPointer >= RAM_BASE |=> lowDataStrobe
    && memAddr == {8'h00, $past(stackPointer)} && stackPointer == $past(stackPointer) + WORD_STEP)
    else $error("push");
  a_push_overflow: assert property (
    pushAcc && stackPointer > stackLimit |=> stackErrorTrap && !lowDataStrobe
    && $stable(stackPointer)) else $error("overflow");
  a_pop_underflow: assert property (
    popAcc && stackPointer < RAM_BASE + WORD_STEP |=> stackErrorTrap && !lowDataStrobe)
    else $error("underflow");
  a_page_hold: assert property (
    !readPageWrite && !writePageWrite |=> $stable(dataReadPage) && $stable(dataWritePage))
    else $error("page moved");
  a_low_direct: assert property (
    plainAcc && !effAddr[15] |=> lowDataStrobe && !addressErrorTrap
    && memAddr == {8'h00, $past(effAddr)}) else $error("low data map");
  a_limit_aligned: assert property (
    stackLimitWrite |=> !stackLimit[0]) else $error("limit bit 0 set");
  a_call_push_clear: assert property (
    pushAcc && pushKind == PUSH_CALL_PC && stackPointer <= stackLimit
    && stackPointer >= RAM_BASE |=> memWriteData[15:8] == 8'h00) else $error("call push");
  c_stack_trap: cover property (stackErrorTrap);
  c_addr_trap: cover property (addressErrorTrap);
  c_upper_word: cover property (progStrobe && upperWordSel);
endmodule // agu_checker

bind data_address_generation_unit agu_checker u_agu_checker (.*);

// *** agu_cpu_model.sv ***
// cpu side model issuing data, table and stack requests
`timescale 1ns/1ns
module agu_cpu_model
  import agu_pkg::*;
(
  input wire logic core_clk,
  output logic accessValid,
  output logic accessWrite,
  output logic [15:0] effAddr,
  output logic [15:0] writeData,
  output logic tableAccess,
  output logic tableHigh,
  output logic stackOp,
  output logic stackPop,
  output push_kind_type pushKind,
  output logic [15:0] pcHighWord,
  output logic [7:0] statusLowByte,
  output logic readPageWrite,
  output logic [9:0] readPageIn,
  output logic writePageWrite,
  output logic [8:0] writePageIn,
  output logic tablePageWrite,
  output logic [7:0] tablePageIn,
  output logic stackLimitWrite,
  output logic [15:0] stackLimitIn,
  output logic stackPointerWrite,
  output logic [15:0] stackPointerIn
);
  initial
  begin
    {accessValid, accessWrite, tableAccess, tableHigh, stackOp, stackPop} = '0;
    {readPageWrite, writePageWrite, tablePageWrite, stackLimitWrite, stackPointerWrite} = '0;
    {effAddr, writeData, readPageIn, writePageIn, tablePageIn, stackLimitIn, stackPointerIn} = '0;
    pushKind = PUSH_DATA;
    pcHighWord = 16'h12C3;
    statusLowByte = 8'h5A;
  end
  // one plain read or write per request, never read-modify-write; valid stays up
  task automatic req(input logic [4:0] f, input logic [15:0] ea, input push_kind_type k);
    accessValid = 1'b1;
    {accessWrite, tableAccess, tableHigh, stackOp, stackPop} = f;
    effAddr = ea;
    writeData = ~ea;
    pushKind = k;
    @(posedge core_clk) #1;
  endtask
  task automatic idle();
    accessValid = 1'b0;
    @(posedge core_clk) #1;
  endtask
  task automatic setup(input logic [9:0] rp, input logic [8:0] wp, input logic [7:0] tp,
    input logic [15:0] lim, input logic [15:0] sp);
    accessValid = 1'b0;
    {readPageIn, writePageIn, tablePageIn, stackLimitIn, stackPointerIn} = {rp, wp, tp, lim, sp};
    {readPageWrite, writePageWrite, tablePageWrite, stackLimitWrite, stackPointerWrite} = '1;
    @(posedge core_clk) #1;
    {readPageWrite, writePageWrite, tablePageWrite, stackLimitWrite, stackPointerWrite} = '0;
    @(posedge core_clk) #1;
  endtask
endmodule // agu_cpu_model

// *** agu_pkg.sv ***
// shared constants and types for the data address generation unit
//
// Rules the document sets for this block
// [R1] write with ea top bit set: address = write page low 9 bits, ea low 15 bits
// [R2] read with ea top bit, read page bit 9 clear: read page low 9, ea low 15
// [R3] page registers never change when a pointer wraps past the window top
// [R4] extended space writes complete in one cycle, no wait cycle
// [R5] addresses below window base ignore both pages, map straight to low data space
// [R6] window access with relevant page zero is invalid, raises address error trap
// [R7] software must not do read-modify-write on extended space inside repeat loops
// [R8] software should pick the page through the read page for read-modify-write
// [R9] stack pointer points at next free word, grows up, post-inc push, pre-dec pop
// [R10] call pushes program counter with its upper byte cleared
// [R11] exception entry puts status low byte in upper byte of pushed counter word
// [R12] stack limit bit 0 always zero; writes to it have no effect
// [R13] stack limit has no reset; undefined until software writes it
// [R14] every stack pointer based address is compared with the stack limit; the code compares push addresses only, not pop addresses
// [R15] push at stack pointer equal to limit is fine; next push traps
// [R16] stack error trap when stack address falls below general ram base
// [R17] software should not read through stack pointer right after writing limit
// [R18] table address = 8-bit table page above full 16-bit effective address
// [R19] table page bit 7 picks user or config memory; reads allowed in config
// [R20] window read with read page bit 9 set: 23-bit address, page low 8, ea low 15
// [R21] program window uses read page bit 0 as program address bit 15
// [R22] read page bit 8 selects lower or upper program word in window access
// [R23] program window remap never reaches configuration space
// [R24] high table variants hit upper program word, low variants lower word
// [R25] traps are one-cycle pulses in the access cycle; the access is suppressed
package agu_pkg;
  localparam int EA_WIDTH = 16;
  localparam int EXT_WIDTH = 24;
  localparam int PROG_WIDTH = 23;
  localparam int RPAGE_WIDTH = 10;
  localparam int WPAGE_WIDTH = 9;
  localparam int TPAGE_WIDTH = 8;
  localparam int WINDOW_BIT = 15;
  localparam int RPAGE_PROG_BIT = 9;
  localparam int RPAGE_WORD_BIT = 8;
  localparam int TPAGE_CFG_BIT = 7;
  localparam logic [15:0] RAM_BASE = 16'h0800;
  localparam logic [15:0] STACK_LIMIT_MASK = 16'hFFFE;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [9:0] RPAGE_RESET = 10'h001;
  localparam logic [8:0] WPAGE_RESET = 9'h001;
  localparam logic [7:0] TPAGE_RESET = 8'h00;
  localparam logic [15:0] SP_RESET = 16'h0800;

  typedef enum logic [2:0] {
    TGT_NONE = 3'b000,
    TGT_LOW_DATA = 3'b001,
    TGT_EXT_DATA = 3'b010,
    TGT_PROG_WINDOW = 3'b011,
    TGT_TABLE = 3'b100
  } target_type;

  typedef enum logic [1:0] {
    STK_NONE = 2'b00,
    STK_PUSH = 2'b01,
    STK_POP = 2'b10
  } stack_op_type;

  typedef enum logic [1:0] {
    PUSH_DATA = 2'b00,
    PUSH_CALL_PC = 2'b01,
    PUSH_EXC_PC = 2'b10
  } push_kind_type;
endpackage

// *** agu_stack_check.sv ***
// stack address generation and limit checking
`timescale 1ns/1ns
module agu_stack_check
  import agu_pkg::*;
(
  agu_stack_if.checker_side stk
);
  always_comb
  begin
    // pop pre-decrements, push uses the pointer as is
    stk.stackAddr = (stk.op == STK_POP) ? 16'(stk.stackPointer - WORD_STEP) : stk.stackPointer; // [R9]
    stk.stackError = 1'b0;
    if (stk.useSp)
    begin
      // equal to limit is the last legal push
      if (stk.op == STK_PUSH && stk.stackAddr > stk.stackLimit) // [R14] [R15]
      begin
        stk.stackError = 1'b1;
      end
      // pointer test as well: a pop from near zero wraps the address upward
      if (stk.stackAddr < RAM_BASE || stk.stackPointer < RAM_BASE) // [R16]
      begin
        stk.stackError = 1'b1;
      end
    end
  end
endmodule // agu_stack_check

// *** agu_stack_if.sv ***
// stack checking signals between the top and the stack checker
`timescale 1ns/1ns
interface agu_stack_if;
  import agu_pkg::*;
  logic [15:0] stackPointer;
  logic [15:0] stackLimit;
  logic [15:0] stackAddr;
  stack_op_type op;
  logic useSp;
  logic stackError;
  modport top (output stackPointer, output stackLimit, output op, output useSp,
    input stackAddr, input stackError);
  modport checker_side (input stackPointer, input stackLimit, input op, input useSp,
    output stackAddr, output stackError);
endinterface

// *** agu_window_map.sv ***
// data address mapping for low, extended and program window accesses
`timescale 1ns/1ns
module agu_window_map
  import agu_pkg::*;
(
  input wire logic [15:0] ea,
  input wire logic isWrite,
  input wire logic [9:0] readPage,
  input wire logic [8:0] writePage,
  output target_type target,
  output logic [23:0] extAddr,
  output logic [22:0] progAddr,
  output logic upperWord,
  output logic addrError
);
  always_comb
  begin
    target = TGT_LOW_DATA;
    extAddr = {8'h00, ea};
    progAddr = '0;
    upperWord = 1'b0;
    addrError = 1'b0;
    if (!ea[WINDOW_BIT])
    begin
      target = TGT_LOW_DATA; // [R5]
    end
    else if (isWrite)
    begin
      extAddr = {writePage, ea[14:0]}; // [R1]
      target = TGT_EXT_DATA;
      if (writePage == '0) // [R6]
      begin
        addrError = 1'b1;
        target = TGT_NONE;
      end
    end
    else if (!readPage[RPAGE_PROG_BIT])
    begin
      extAddr = {readPage[8:0], ea[14:0]}; // [R2]
      target = TGT_EXT_DATA;
      if (readPage == '0) // [R6]
      begin
        addrError = 1'b1;
        target = TGT_NONE;
      end
    end
    else
    begin
      // top address bit held low keeps the remap out of config space
      progAddr = {readPage[7:1], readPage[0], ea[14:0]}; // [R20] [R21] [R23]
      upperWord = readPage[RPAGE_WORD_BIT]; // [R22]
      target = TGT_PROG_WINDOW;
    end
  end
endmodule // agu_window_map

// *** data_address_generation_unit.sv ***
// top of the data address generation unit: page registers, stack, table access
`timescale 1ns/1ns
module data_address_generation_unit
  import agu_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic accessValid,
  input wire logic accessWrite,
  input wire logic [15:0] effAddr,
  input wire logic [15:0] writeData,
  input wire logic tableAccess,
  input wire logic tableHigh,
  input wire logic stackOp,
  input wire logic stackPop,
  input wire push_kind_type pushKind,
  input wire logic [15:0] pcHighWord,
  input wire logic [7:0] statusLowByte,
  input wire logic readPageWrite,
  input wire logic [9:0] readPageIn,
  input wire logic writePageWrite,
  input wire logic [8:0] writePageIn,
  input wire logic tablePageWrite,
  input wire logic [7:0] tablePageIn,
  input wire logic stackLimitWrite,
  input wire logic [15:0] stackLimitIn,
  input wire logic stackPointerWrite,
  input wire logic [15:0] stackPointerIn,
  output logic [9:0] dataReadPage,
  output logic [8:0] dataWritePage,
  output logic [7:0] tablePage,
  output logic [15:0] stackLimit,
  output logic [15:0] stackPointer,
  output logic lowDataStrobe,
  output logic extDataStrobe,
  output logic progStrobe,
  output logic memWrite,
  output logic [23:0] memAddr,
  output logic [15:0] memWriteData,
  output logic upperWordSel,
  output logic configSpace,
  output logic addressErrorTrap,
  output logic stackErrorTrap
);
  typedef struct packed {
    logic [9:0] readPage;
    logic [8:0] writePage;
    logic [7:0] tablePage;
    logic [15:0] stackPointer;
    logic lowStrobe;
    logic extStrobe;
    logic progStrobe;
    logic write;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic upper;
    logic cfgSpace;
    logic addrTrap;
    logic stackTrap;
  } state_type;

  state_type state_q;
  state_type state_d;
  logic [15:0] stackLimit_q;
  logic [15:0] mapEa;
  target_type mapTarget;
  logic [23:0] mapExt;
  logic [22:0] mapProg;
  logic mapUpper;
  logic mapError;
  logic [15:0] pushWord;

  agu_stack_if stk();

  assign stk.stackPointer = state_q.stackPointer;
  assign stk.stackLimit = stackLimit_q;
  assign stk.op = !stackOp ? STK_NONE : (stackPop ? STK_POP : STK_PUSH);
  assign stk.useSp = accessValid && stackOp;
  assign mapEa = stackOp ? stk.stackAddr : effAddr;

  agu_stack_check u_stack (
    .stk(stk)
  );

  agu_window_map u_map (
    .ea(mapEa),
    .isWrite(accessWrite),
    .readPage(state_q.readPage),
    .writePage(state_q.writePage),
    .target(mapTarget),
    .extAddr(mapExt),
    .progAddr(mapProg),
    .upperWord(mapUpper),
    .addrError(mapError)
  );

  always_comb
  begin
    unique case (pushKind)
      PUSH_CALL_PC: pushWord = {8'h00, pcHighWord[7:0]}; // [R10]
      PUSH_EXC_PC: pushWord = {statusLowByte, pcHighWord[7:0]}; // [R11]
      default: pushWord = writeData;
    endcase
  end

  // limit register deliberately has no reset; bit 0 is held at zero
  always_ff @(posedge core_clk)
  begin
    if (stackLimitWrite) // [R13]
    begin
      stackLimit_q <= stackLimitIn & STACK_LIMIT_MASK; // [R12]
    end
  end

  always_comb
  begin
    state_d = state_q;
    state_d.lowStrobe = 1'b0;
    state_d.extStrobe = 1'b0;
    state_d.progStrobe = 1'b0;
    state_d.write = 1'b0;
    state_d.addrTrap = 1'b0;
    state_d.stackTrap = 1'b0;
    // page registers only change on explicit writes, never on pointer wrap
    if (readPageWrite) // [R3]
    begin
      state_d.readPage = readPageIn;
    end
    if (writePageWrite) // [R3]
    begin
      state_d.writePage = writePageIn;
    end
    if (tablePageWrite)
    begin
      state_d.tablePage = tablePageIn;
    end
    if (stackPointerWrite)
    begin
      state_d.stackPointer = stackPointerIn & STACK_LIMIT_MASK;
    end
    if (accessValid)
    begin
      state_d.wdata = (stackOp && !stackPop) ? pushWord : writeData;
      state_d.upper = 1'b0;
      state_d.cfgSpace = 1'b0;
      if (tableAccess)
      begin
        state_d.addr = {state_q.tablePage, effAddr}; // [R18]
        state_d.upper = tableHigh; // [R24]
        state_d.cfgSpace = state_q.tablePage[TPAGE_CFG_BIT]; // [R19]
        // writes into config space are not allowed, reads are
        if (!(accessWrite && state_q.tablePage[TPAGE_CFG_BIT])) // [R19]
        begin
          state_d.progStrobe = 1'b1;
          state_d.write = accessWrite;
        end
      end
      else if (stk.stackError) // [R25]
      begin
        state_d.stackTrap = 1'b1;
      end
      else if (mapError) // [R25]
      begin
        state_d.addrTrap = 1'b1;
      end
      else
      begin
        state_d.write = accessWrite; // [R4]
        unique case (mapTarget)
          TGT_LOW_DATA:
          begin
            state_d.addr = {8'h00, mapEa}; // [R5]
            state_d.lowStrobe = 1'b1;
          end
          TGT_EXT_DATA:
          begin
            state_d.addr = mapExt;
            state_d.extStrobe = 1'b1;
          end
          TGT_PROG_WINDOW:
          begin
            state_d.addr = {1'b0, mapProg};
            state_d.upper = mapUpper;
            state_d.progStrobe = 1'b1;
            state_d.write = 1'b0;
          end
          default:
          begin
            state_d.write = 1'b0;
          end
        endcase
        if (stackOp) // [R9]
        begin
          state_d.stackPointer = stackPop ? stk.stackAddr :
            16'(state_q.stackPointer + WORD_STEP);
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= '0;
      state_q.readPage <= RPAGE_RESET;
      state_q.writePage <= WPAGE_RESET;
      state_q.tablePage <= TPAGE_RESET;
      state_q.stackPointer <= SP_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign dataReadPage = state_q.readPage;
  assign dataWritePage = state_q.writePage;
  assign tablePage = state_q.tablePage;
  assign stackLimit = stackLimit_q;
  assign stackPointer = state_q.stackPointer;
  assign lowDataStrobe = state_q.lowStrobe;
  assign extDataStrobe = state_q.extStrobe;
  assign progStrobe = state_q.progStrobe;
  assign memWrite = state_q.write;
  assign memAddr = state_q.addr;
  assign memWriteData = state_q.wdata;
  assign upperWordSel = state_q.upper;
  assign configSpace = state_q.cfgSpace;
  assign addressErrorTrap = state_q.addrTrap;
  assign stackErrorTrap = state_q.stackTrap;
endmodule // data_address_generation_unit

// *** test_data_address_generation_unit.sv ***
// self-checking bench for the data address generation unit
`timescale 1ns/1ns
module test_data_address_generation_unit;
  import agu_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic accessValid, accessWrite, tableAccess, tableHigh, stackOp, stackPop, readPageWrite;
  logic writePageWrite, tablePageWrite, stackLimitWrite, stackPointerWrite, lowDataStrobe;
  logic extDataStrobe, progStrobe, memWrite, upperWordSel, configSpace;
  logic addressErrorTrap, stackErrorTrap;
  logic [15:0] effAddr, writeData, pcHighWord, stackLimitIn, stackPointerIn;
  logic [15:0] stackLimit, stackPointer, memWriteData;
  logic [9:0] readPageIn, dataReadPage;
  logic [8:0] writePageIn, dataWritePage;
  logic [7:0] tablePageIn, tablePage, statusLowByte;
  logic [23:0] memAddr;
  push_kind_type pushKind;
  int badCount = 0;
  int samplesChecked = 0;
  int cycles = 0;
  data_address_generation_unit u_data_address_generation_unit (.*);
  agu_cpu_model u_agu_cpu_model (.*);
  always #5 core_clk = ~core_clk;
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      badCount++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      badCount++;
      printVerdict();
    end
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    #1 arst_n = 1'b1;
    cmp({dataReadPage, dataWritePage, tablePage}, {RPAGE_RESET, WPAGE_RESET, TPAGE_RESET});
    u_agu_cpu_model.setup(10'h002, 9'h002, 8'h81, 16'h0805, 16'h0800);
    cmp(stackLimit, 16'h0804);
    u_agu_cpu_model.req(5'b10000, 16'h8800, PUSH_DATA);
    cmp({extDataStrobe, memWrite, memAddr}, {2'b11, 24'h01_0800});
    cmp(memWriteData, 16'h77FF);
    u_agu_cpu_model.req(5'b10000, 16'hFFFE, PUSH_DATA);
    cmp({extDataStrobe, memAddr}, {1'b1, 24'h01_7FFE});
    u_agu_cpu_model.req(5'b00000, 16'h8000, PUSH_DATA);
    cmp({extDataStrobe, memWrite, memAddr}, {2'b10, 24'h01_0000});
    cmp({dataReadPage, dataWritePage}, {10'h002, 9'h002});
    u_agu_cpu_model.req(5'b00000, 16'h7FFE, PUSH_DATA);
    cmp({lowDataStrobe, extDataStrobe, memAddr}, {2'b10, 24'h00_7FFE});
    u_agu_cpu_model.req(5'b01100, 16'hBEEF, PUSH_DATA);
    cmp({progStrobe, configSpace, upperWordSel, memAddr}, {3'b111, 24'h81_BEEF});
    u_agu_cpu_model.req(5'b01000, 16'h0010, PUSH_DATA);
    cmp({progStrobe, configSpace, upperWordSel, memAddr}, {3'b110, 24'h81_0010});
    u_agu_cpu_model.req(5'b11000, 16'h0010, PUSH_DATA);
    cmp({progStrobe, addressErrorTrap}, 2'b00);
    u_agu_cpu_model.setup(10'h301, 9'h002, 8'h01, 16'h0802, 16'h0800);
    u_agu_cpu_model.req(5'b00000, 16'h800A, PUSH_DATA);
    cmp({progStrobe, configSpace, upperWordSel, memAddr}, {3'b101, 24'h00_800A});
    u_agu_cpu_model.req(5'b11000, 16'h0020, PUSH_DATA);
    cmp({progStrobe, memWrite, configSpace, memAddr}, {3'b110, 24'h01_0020});
    u_agu_cpu_model.setup(10'h000, 9'h000, 8'h00, 16'h0802, 16'h0800);
    u_agu_cpu_model.req(5'b00000, 16'h9000, PUSH_DATA);
    cmp({addressErrorTrap, extDataStrobe, progStrobe}, 3'b100);
    u_agu_cpu_model.req(5'b10000, 16'hFFFE, PUSH_DATA);
    cmp({addressErrorTrap, extDataStrobe, progStrobe}, 3'b100);
    u_agu_cpu_model.req(5'b10000, 16'h0800, PUSH_DATA);
    cmp({lowDataStrobe, addressErrorTrap, memAddr}, {2'b10, 24'h00_0800});
    u_agu_cpu_model.req(5'b10010, 16'h0000, PUSH_EXC_PC);
    cmp({lowDataStrobe, memAddr}, {1'b1, 24'h00_0800});
    cmp({memWriteData, stackPointer}, {16'h5AC3, 16'h0802});
    u_agu_cpu_model.req(5'b10010, 16'h0000, PUSH_CALL_PC);
    cmp({stackErrorTrap, memWriteData, stackPointer}, {1'b0, 16'h00C3, 16'h0804});
    u_agu_cpu_model.req(5'b10010, 16'h0000, PUSH_DATA);
    cmp({stackErrorTrap, lowDataStrobe, stackPointer}, {2'b10, 16'h0804});
    u_agu_cpu_model.req(5'b00011, 16'h0000, PUSH_DATA);
    cmp({lowDataStrobe, memAddr[11:0], stackPointer}, {1'b1, 12'h802, 16'h0802});
    u_agu_cpu_model.req(5'b00011, 16'h0000, PUSH_DATA);
    cmp({lowDataStrobe, memAddr[11:0], stackPointer}, {1'b1, 12'h800, 16'h0800});
    u_agu_cpu_model.req(5'b00011, 16'h0000, PUSH_DATA);
    cmp({stackErrorTrap, lowDataStrobe, stackPointer}, {2'b10, 16'h0800});
    u_agu_cpu_model.idle();
    cmp({stackErrorTrap, addressErrorTrap}, 2'b00);
    arst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 arst_n = 1'b1;
    cmp(stackLimit, 16'h0802);
    cmp(stackPointer, SP_RESET);
    printVerdict();
  end
endmodule // test_data_address_generation_unit
